// ===== hw/timer8_irq.sv
module timer8_irq
   import timer8_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic global_irq_en,
   input wire logic [EVT_W-1:0] vector_done,
   output logic [EVT_W-1:0] irq_req,
   output logic irq,
   output logic wave_out_a,
   output logic wave_out_b
);

   // Bus slave state
   logic ack_q; // Acknowledge, one cycle
   logic ack_d;
   logic [31:0] dat_q; // Read data held for the ack cycle
   logic [31:0] dat_d;

   // Software visible state
   logic [EVT_W-1:0] flags_q; // Sticky event flags
   logic [EVT_W-1:0] flags_d;
   logic [EVT_W-1:0] mask_q; // Per-event enables
   logic [EVT_W-1:0] mask_d;
   logic [DATA_W-1:0] cmp_a_q; // Channel A compare value
   logic [DATA_W-1:0] cmp_a_d;
   logic [DATA_W-1:0] cmp_b_q; // Channel B compare value
   logic [DATA_W-1:0] cmp_b_d;
   logic [CTRL_W-1:0] ctrl_q; // Clock select and mode
   logic [CTRL_W-1:0] ctrl_d;

   // Counter state
   logic [DATA_W-1:0] cnt_q; // Running count
   logic [DATA_W-1:0] cnt_d;
   logic down_q; // Counting down in phase correct modes
   logic down_d;
   logic block_q; // Match blocked until next tick
   logic block_d;
   logic [PSC_W-1:0] psc_q; // Free running prescaler
   logic [PSC_W-1:0] psc_d;

   // Waveform outputs
   logic wave_a_q;
   logic wave_a_d;
   logic wave_b_q;
   logic wave_b_d;

   // Decoded helpers
   logic req; // Request present
   logic wr_fire; // Write takes effect this edge
   logic [IDX_W-1:0] idx; // Register index from byte address
   logic [2:0] cs; // Clock select field
   logic [2:0] mode; // Waveform mode field
   logic tick; // Timer clock enable
   logic pwm; // A PWM mode is selected
   logic phase; // Phase correct mode is selected
   logic [DATA_W-1:0] top; // Top of count sequence
   logic at_bottom; // Count is zero
   logic at_max; // Count is 255
   logic wrap_evt; // Overflow event this cycle
   logic force_a; // Forced compare strobe A
   logic force_b; // Forced compare strobe B
   logic [EVT_W-1:0] sw_clr; // Software clear bits
   logic [EVT_W-1:0] hw_set; // Hardware set bits

   // Compare channel bundles
   match_if ma ();
   match_if mb ();

   assign req = cyc_i && stb_i;
   assign idx = adr_i[ADR_W-1:2];
   assign wr_fire = req && we_i && ack_q && sel_i[0];
   assign cs = ctrl_q[CTRL_CS_LSB +: 3];
   assign mode = ctrl_q[CTRL_MODE_LSB +: 3];

   // Count landmarks
   assign at_bottom = (cnt_q == CNT_BOTTOM);
   assign at_max = (cnt_q == CNT_MAX);

   // Mode decode
   assign phase = (mode == MODE_PC_MAX) || (mode == MODE_PC_CMPA);
   assign pwm = phase || (mode == MODE_FAST_MAX) ||
                (mode == MODE_FAST_CMPA);

   // Top is compare A in CTC and the compare A PWM modes
   always_comb begin
      if ((mode == MODE_CTC) || (mode == MODE_PC_CMPA) ||
          (mode == MODE_FAST_CMPA)) begin
         top = cmp_a_q;
      end else begin
         top = CNT_MAX;
      end
   end

   // Prescaler next value, always counting
   always_comb begin
      psc_d = psc_q + 1'b1;
   end

   // Timer tick from the selected prescaler tap
   always_comb begin
      case (cs)
         CS_DIV1: begin
            tick = 1'b1;
         end
         CS_DIV8: begin
            tick = &psc_q[TAP_DIV8-1:0];
         end
         CS_DIV64: begin
            tick = &psc_q[TAP_DIV64-1:0];
         end
         CS_DIV256: begin
            tick = &psc_q[TAP_DIV256-1:0];
         end
         CS_DIV1024: begin
            tick = &psc_q;
         end
         default: begin
            // Stopped, and no external source is wired
            tick = 1'b0;
         end
      endcase
   end

   // Counter sequencing and overflow detection
   always_comb begin
      cnt_d = cnt_q;
      down_d = down_q;
      block_d = block_q;
      wrap_evt = 1'b0;
      if (wr_fire && (idx == IDX_COUNT)) begin
         // Software write overrides counting
         cnt_d = dat_i[DATA_W-1:0];
         block_d = 1'b1;
      end else if (tick) begin
         block_d = 1'b0;
         if (phase) begin
            if (down_q) begin
               if (at_bottom) begin
                  // Turn at bottom, overflow flagged here
                  down_d = 1'b0;
                  cnt_d = cnt_q + 1'b1;
                  wrap_evt = 1'b1;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end else if (cnt_q == top) begin
               // Turn at top
               down_d = 1'b1;
               cnt_d = cnt_q - 1'b1;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end else begin
            down_d = 1'b0;
            if (mode == MODE_FAST_CMPA) begin
               // Overflow at top only in fast PWM with compare A as top, not in CTC
               wrap_evt = (cnt_q == top);
            end else begin
               // Overflow at maximum otherwise
               wrap_evt = at_max;
            end
            if (cnt_q == top) begin
               // Clear on top; forced strobes never reach here
               cnt_d = CNT_BOTTOM;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
      end
   end

   // Channel wiring
   assign ma.count = cnt_q;
   assign ma.value = cmp_a_q;
   assign ma.tick = tick;
   assign ma.suppress = block_q;
   assign mb.count = cnt_q;
   assign mb.value = cmp_b_q;
   assign mb.tick = tick;
   assign mb.suppress = block_q;

   compare_chan chan_a (
      .clk(clk),
      .rst(rst),
      .m(ma.chan)
   );

   compare_chan chan_b (
      .clk(clk),
      .rst(rst),
      .m(mb.chan)
   );

   // Forced strobes only act outside PWM modes
   assign force_a = wr_fire && (idx == IDX_CTRL) &&
                    dat_i[CTRL_FORCE_A] && !pwm;
   assign force_b = wr_fire && (idx == IDX_CTRL) &&
                    dat_i[CTRL_FORCE_B] && !pwm;

   // Waveform outputs toggle on a match or a forced strobe
   always_comb begin
      wave_a_d = wave_a_q ^ (ma.hit || force_a);
      wave_b_d = wave_b_q ^ (mb.hit || force_b);
   end

   // Event sources, forced strobes are deliberately absent
   always_comb begin
      hw_set = '0;
      hw_set[BIT_WRAP] = wrap_evt;
      hw_set[BIT_MATCH_A] = ma.hit;
      hw_set[BIT_MATCH_B] = mb.hit;
   end

   // Clears from write-one, the clear alias and vector execution
   always_comb begin
      sw_clr = vector_done;
      if (wr_fire && ((idx == IDX_FLAGS) || (idx == IDX_CLEAR))) begin
         // Only ones clear, zeros leave the flag alone
         sw_clr = sw_clr | dat_i[EVT_W-1:0];
      end
   end

   // Sticky flags, a set in the same cycle wins over a clear
   always_comb begin
      flags_d = (flags_q & ~sw_clr) | hw_set;
   end

   // Software writes to the plain registers
   always_comb begin
      mask_d = mask_q;
      cmp_a_d = cmp_a_q;
      cmp_b_d = cmp_b_q;
      ctrl_d = ctrl_q;
      if (wr_fire) begin
         case (idx)
            IDX_MASK: begin
               mask_d = dat_i[EVT_W-1:0];
            end
            IDX_CMP_A: begin
               cmp_a_d = dat_i[DATA_W-1:0];
            end
            IDX_CMP_B: begin
               cmp_b_d = dat_i[DATA_W-1:0];
            end
            IDX_CTRL: begin
               // Force strobes are not stored
               ctrl_d = dat_i[CTRL_W-1:0];
            end
            default: begin
               ctrl_d = ctrl_q;
            end
         endcase
      end
   end

   // Bus answer: ack one cycle after the request, read data with it
   always_comb begin
      ack_d = req && !ack_q;
      dat_d = '0;
      if (ack_d && !we_i) begin
         case (idx)
            IDX_FLAGS: begin
               dat_d[EVT_W-1:0] = flags_q;
            end
            IDX_MASK: begin
               dat_d[EVT_W-1:0] = mask_q;
            end
            IDX_CMP_A: begin
               dat_d[DATA_W-1:0] = cmp_a_q;
            end
            IDX_CMP_B: begin
               dat_d[DATA_W-1:0] = cmp_b_q;
            end
            IDX_CTRL: begin
               // Force bits read as zero
               dat_d[CTRL_W-1:0] = ctrl_q;
            end
            IDX_COUNT: begin
               dat_d[DATA_W-1:0] = cnt_q;
            end
            default: begin
               // Clear alias and unmapped read as zero
               dat_d = '0;
            end
         endcase
      end
   end

   // Register all state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         dat_q <= '0;
         flags_q <= FLAGS_RST;
         mask_q <= MASK_RST;
         cmp_a_q <= CMP_RST;
         cmp_b_q <= CMP_RST;
         ctrl_q <= CTRL_RST;
         cnt_q <= COUNT_RST;
         down_q <= 1'b0;
         block_q <= 1'b0;
         psc_q <= '0;
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         flags_q <= flags_d;
         mask_q <= mask_d;
         cmp_a_q <= cmp_a_d;
         cmp_b_q <= cmp_b_d;
         ctrl_q <= ctrl_d;
         cnt_q <= cnt_d;
         down_q <= down_d;
         block_q <= block_d;
         psc_q <= psc_d;
         wave_a_q <= wave_a_d;
         wave_b_q <= wave_b_d;
      end
   end

   // Requests need flag, enable and the global enable together
   always_comb begin
      irq_req = '0;
      irq_req[BIT_MATCH_B] = flags_q[BIT_MATCH_B] &&
                             mask_q[BIT_MATCH_B] && global_irq_en;
      irq_req[BIT_MATCH_A] = flags_q[BIT_MATCH_A] &&
                             mask_q[BIT_MATCH_A] && global_irq_en;
      irq_req[BIT_WRAP] = flags_q[BIT_WRAP] &&
                          mask_q[BIT_WRAP] && global_irq_en;
   end

   assign irq = |irq_req;
   assign ack_o = ack_q;
   assign dat_o = dat_q;
   assign wave_out_a = wave_a_q;
   assign wave_out_b = wave_b_q;

endmodule

// ===== hw/timer8_pkg.sv
package timer8_pkg;

   // Data and address widths of the register port
   localparam int DATA_W = 8;
   localparam int ADR_W = 8;
   localparam int IDX_W = 6;

   // Register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h38;
   localparam logic [IDX_W-1:0] IDX_MASK = 6'h39;
   localparam logic [IDX_W-1:0] IDX_CMP_A = 6'h3A;
   localparam logic [IDX_W-1:0] IDX_CTRL = 6'h3B;
   localparam logic [IDX_W-1:0] IDX_CMP_B = 6'h3C;
   localparam logic [IDX_W-1:0] IDX_COUNT = 6'h3E;
   localparam logic [IDX_W-1:0] IDX_CLEAR = 6'h3F;

   // Event bit positions, shared by flags, mask and clear registers
   localparam int EVT_W = 3;
   localparam int BIT_WRAP = 0;
   localparam int BIT_MATCH_A = 1;
   localparam int BIT_MATCH_B = 2;

   // Control register layout
   localparam int CTRL_W = 6;
   localparam int CTRL_CS_LSB = 0;
   localparam int CTRL_MODE_LSB = 3;
   localparam int CTRL_FORCE_B = 6;
   localparam int CTRL_FORCE_A = 7;

   // Reset values
   localparam logic [EVT_W-1:0] FLAGS_RST = 3'h0;
   localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
   localparam logic [DATA_W-1:0] CMP_RST = 8'h00;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;

   // Count landmarks
   localparam logic [DATA_W-1:0] CNT_BOTTOM = 8'h00;
   localparam logic [DATA_W-1:0] CNT_MAX = 8'hFF;

   // Waveform generation modes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_MAX = 3'h1;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] MODE_PC_CMPA = 3'h5;
   localparam logic [2:0] MODE_FAST_CMPA = 3'h7;

   // Clock select codes and prescaler tap widths
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam int PSC_W = 10;
   localparam int TAP_DIV8 = 3;
   localparam int TAP_DIV64 = 6;
   localparam int TAP_DIV256 = 8;

endpackage

// ===== hw/match_if.sv
// Bundle between the counter core and one compare channel
interface match_if;
   import timer8_pkg::*;
   logic [DATA_W-1:0] count; // Running count
   logic [DATA_W-1:0] value; // Compare value of this channel
   logic tick; // Timer clock enable
   logic suppress; // Match blocked on this tick
   logic hit; // One-cycle match pulse
   modport timer (
      output count,
      output value,
      output tick,
      output suppress,
      input hit
   );
   modport chan (
      input count,
      input value,
      input tick,
      input suppress,
      output hit
   );
endinterface

// ===== hw/compare_chan.sv
// One compare channel: flags equality of count and value on a tick
module compare_chan
   import timer8_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   match_if.chan m
);

   logic hit_q; // Registered match pulse
   logic hit_d; // Next match pulse

   // Equality checked on every timer tick unless blocked
   always_comb begin
      hit_d = m.tick && (m.count == m.value) && !m.suppress;
   end

   // Register the pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hit_q <= 1'b0;
      end else begin
         hit_q <= hit_d;
      end
   end

   assign m.hit = hit_q;

endmodule

// ===== verif/timer8_irq_properties.sv
module timer8_irq_properties
   import timer8_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic global_irq_en,
   input wire logic [EVT_W-1:0] irq_req,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [EVT_W-1:0] mask_d, mask_q; // Shadow of the enable bits
   logic tk; // Write taken at this edge

   // Follow mask writes at the edge that acks them
   always_comb begin
      tk = cyc_i && stb_i && we_i && ack_o && sel_i[0];
      mask_d = (tk && adr_i[7:2] == IDX_MASK) ? dat_i[2:0] : mask_q;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) mask_q <= MASK_RST;
      else mask_q <= mask_d;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_ack_next;
      cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not acked");
   property p_ack_drop;
      ack_o |=> !ack_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack longer than one cycle");
   property p_flags_hi;
      ack_o && !we_i && adr_i[7:2] == IDX_FLAGS |-> dat_o[31:3] == 29'h0;
   endproperty
   a_flags_hi: assert property (p_flags_hi)
      else $error("reserved flag bits set");
   property p_mask_rd;
      ack_o && !we_i && adr_i[7:2] == IDX_MASK |-> dat_o == {29'h0, mask_q};
   endproperty
   a_mask_rd: assert property (p_mask_rd)
      else $error("mask read wrong");
   property p_req_wrap;
      irq_req[BIT_WRAP] |-> global_irq_en && mask_q[BIT_WRAP];
   endproperty
   a_req_wrap: assert property (p_req_wrap)
      else $error("wrap request not enabled");
   property p_req_a;
      irq_req[BIT_MATCH_A] |-> global_irq_en && mask_q[BIT_MATCH_A];
   endproperty
   a_req_a: assert property (p_req_a)
      else $error("match A request not enabled");
   property p_req_b;
      irq_req[BIT_MATCH_B] |-> global_irq_en && mask_q[BIT_MATCH_B];
   endproperty
   a_req_b: assert property (p_req_b)
      else $error("match B request not enabled");
   property p_irq_or;
      irq == (|irq_req);
   endproperty
   a_irq_or: assert property (p_irq_or)
      else $error("irq differs from requests");
endmodule

bind timer8_irq timer8_irq_properties u_props (
   .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .ack_o(ack_o), .global_irq_en(global_irq_en), .irq_req(irq_req),
   .irq(irq)
);

// ===== verif/cpu_core_model.sv
module cpu_core_model
   import timer8_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [EVT_W-1:0] irq_req,
   input wire logic ie,
   input wire logic serve,
   input wire logic [3:0] lat,
   output logic global_irq_en,
   output logic [EVT_W-1:0] vector_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q; // Cycles left before entering a vector

   // Global enable follows the bench; a vector enters lat cycles later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         global_irq_en <= 1'b0;
         vector_done <= '0;
         wait_q <= 4'h0;
      end else begin
         global_irq_en <= ie;
         vector_done <= '0;
         if (wait_q == 4'h1) begin // Enter the lowest pending vector
            vector_done <= irq_req & (~irq_req + 3'h1);
            wait_q <= 4'h0;
         end else if (wait_q != 4'h0) begin // Still fetching
            wait_q <= wait_q - 4'h1;
         end else if (serve && irq_req != '0) begin // Request seen
            wait_q <= lat;
         end
      end
   end
endmodule

// ===== verif/timer8_compare_interrupt_flags_tb.sv
module timer8_compare_interrupt_flags_tb
   import timer8_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, cyc_i, stb_i, we_i, ack_o, irq, ie, serve;
   logic global_irq_en, wave_out_a, wave_out_b;
   logic [3:0] sel_i, lat;
   logic [7:0] adr_i, r, a, b, c;
   logic [31:0] dat_i, dat_o;
   logic [EVT_W-1:0] vector_done, irq_req, e_q;
   int mdl [64]; // Expected register contents by index
   bit wa, wb; // Expected wave levels
   int seed = 32'h5A11;
   int bad_count, n_checks;
   logic [5:0] regs [8] = '{IDX_FLAGS, IDX_MASK, IDX_CMP_A, IDX_CTRL,
      IDX_CMP_B, IDX_COUNT, IDX_CLEAR, 6'h00};
   logic [2:0] modes [5] = '{MODE_CTC, MODE_FAST_MAX, MODE_FAST_CMPA,
      MODE_PC_MAX, MODE_PC_CMPA};
   logic [2:0] mexp [5] = '{3'h2, 3'h7, 3'h3, 3'h7, 3'h3};
   // Prescaler codes under test, the last one is a stopped code
   logic [2:0] divs [5] = '{CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024,
      3'h6};
   // Cycles per tick of each running code above; 64 cycles of wait for the stopped one
   int dlen [5] = '{1 << TAP_DIV8, 1 << TAP_DIV64, 1 << TAP_DIV256,
      1 << PSC_W, 64};

   timer8_irq dut (
      .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .global_irq_en(global_irq_en),
      .vector_done(vector_done), .irq_req(irq_req), .irq(irq),
      .wave_out_a(wave_out_a), .wave_out_b(wave_out_b)
   );
   cpu_core_model u_cpu (
      .clk(clk), .rst(rst), .irq_req(irq_req), .ie(ie), .serve(serve),
      .lat(lat), .global_irq_en(global_irq_en), .vector_done(vector_done)
   );

   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Compare and count
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One Wishbone cycle; reads are compared, writes update the model
   task automatic acc(input bit w, input logic [5:0] idx,
      input logic [7:0] d);
      @(posedge clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      // Wait for the answer; only the hang guard ends a lost one
      do begin
         @(posedge clk);
      end while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (!w) check("register", dat_o, mdl[idx]);
      else if (idx == IDX_MASK) mdl[idx] = d & 8'h07;
      else if (idx == IDX_CTRL) mdl[idx] = d & 8'h3F;
      else if (idx inside {IDX_FLAGS, IDX_CLEAR}) mdl[IDX_FLAGS] &= ~d;
      else if (idx inside {IDX_CMP_A, IDX_CMP_B, IDX_COUNT}) mdl[idx] = d;
      wa ^= w && idx == IDX_CTRL && d[7];
      wb ^= w && idx == IDX_CTRL && d[6];
   endtask

   // Request lines against mask, flags and global enable
   task automatic chk_irq();
      e_q = 3'(mdl[IDX_MASK] & mdl[IDX_FLAGS]) & {3{ie}};
      check("irq_req", irq_req, e_q);
      check("irq", irq, |e_q);
   endtask

   // Counts and verdict
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst, ie, serve, wa, wb} = 5'b10000;
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      sel_i = 4'hF;
      lat = 4'h1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[i]) acc(0, regs[i], 0);
      foreach (regs[i]) begin
         if (regs[i] != IDX_CTRL) acc(1, regs[i], 8'($random(seed)));
         acc(0, regs[i], 0);
      end
      for (int e = 0; e < 3; e++) begin
         r = 8'($random(seed) & 15);
         a = (e == 1) ? 8'h20 + r : 8'h80;
         b = (e == 2) ? 8'h20 + r : 8'h90;
         c = (e == 0) ? 8'hF0 + r : 8'h08;
         acc(1, IDX_MASK, 0);
         acc(1, IDX_CMP_A, a);
         acc(1, IDX_CMP_B, b);
         acc(1, IDX_COUNT, c);
         acc(1, IDX_CTRL, {2'b00, MODE_NORMAL, CS_DIV1});
         repeat (48) @(posedge clk);
         acc(1, IDX_CTRL, 0);
         mdl[IDX_FLAGS] = 1 << e;
         wa ^= (e == 1);
         wb ^= (e == 2);
         acc(0, IDX_FLAGS, 0);
         acc(1, IDX_FLAGS, 0);
         acc(0, IDX_FLAGS, 0);
         for (int k = 0; k < 4; k++) begin
            ie <= k[0];
            acc(1, IDX_MASK, (k > 1) ? 8'h01 << e : 8'h00);
            repeat (2) @(posedge clk);
            chk_irq();
         end
         if (e == 0) begin
            acc(1, IDX_FLAGS, 8'h01);
         end else begin
            lat <= (e == 1) ? 4'h1 : 4'h7;
            serve <= 1'b1;
            repeat (12) @(posedge clk);
            serve <= 1'b0;
            mdl[IDX_FLAGS] = 0;
         end
         acc(0, IDX_FLAGS, 0);
         chk_irq();
      end
      ie <= 1'b0;
      acc(1, IDX_CTRL, 8'h80);
      acc(1, IDX_CTRL, 8'h40);
      acc(0, IDX_CTRL, 0);
      acc(0, IDX_FLAGS, 0);
      check("wave_a", wave_out_a, wa);
      check("wave_b", wave_out_b, wb);
      acc(1, IDX_CMP_A, 8'h40);
      acc(1, IDX_COUNT, 8'h40);
      acc(1, IDX_CTRL, {2'b00, MODE_NORMAL, CS_DIV1});
      repeat (20) @(posedge clk);
      acc(1, IDX_CTRL, 0);
      acc(0, IDX_FLAGS, 0);
      foreach (modes[i]) begin
         acc(1, IDX_CLEAR, 8'hFF);
         acc(1, IDX_COUNT, 0);
         acc(1, IDX_CMP_A, 8'h10);
         acc(1, IDX_CMP_B, 8'h90);
         acc(1, IDX_CTRL, {2'b00, modes[i], CS_DIV1});
         acc(0, IDX_CTRL, 0);
         repeat (600) @(posedge clk);
         acc(1, IDX_CTRL, 0);
         mdl[IDX_FLAGS] = mexp[i];
         acc(0, IDX_FLAGS, 0);
      end
      // Each prescaler tap wraps a count of 255; code 6 stays stopped
      foreach (divs[i]) begin
         acc(1, IDX_CLEAR, 8'hFF);
         acc(1, IDX_COUNT, CNT_MAX);
         acc(1, IDX_CTRL, {2'b00, MODE_NORMAL, divs[i]});
         repeat (dlen[i] + 8) @(posedge clk);
         acc(1, IDX_CTRL, 0);
         mdl[IDX_FLAGS] = (i < 4) ? (1 << BIT_WRAP) : 0;
         acc(0, IDX_FLAGS, 0);
      end
      // Mid-run reset returns every register and wave to reset values
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      mdl = '{default: 0};
      {wa, wb} = 2'b00;
      foreach (regs[i]) acc(0, regs[i], 0);
      check("wave_a", wave_out_a, wa);
      check("wave_b", wave_out_b, wb);
      report_and_stop();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
endmodule
